// >>> src/cmsc_top.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Configuration manager status and control
// ============================================================
module cmsc_top #(
  parameter int unsigned BLINK_HALF = cmsc_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  // Source requests and routing
  input wire logic [1:0] src_sel_i, // Requested configuration source
  input wire logic start_i, // Start a configuration attempt
  input wire logic done_i, // Chain reports successful end
  input wire logic error_i, // Any error during attempt
  input wire logic card_detect_n_i, // Card present, active low
  input wire logic [2:0] design_select_inputs_i, // Pin design select
  input wire logic [2:0] mpu_design_sel_i, // Register design select
  input wire logic mpu_design_sel_en_i, // Use register select
  input wire logic [2:0] rate_sel_i, // Shift rate, 0 fastest
  // Card buffer requests
  input wire logic mpu_buf_req_i,
  input wire logic jtag_buf_req_i,
  output logic mpu_buf_gnt_o,
  output logic jtag_buf_gnt_o,
  // Test scan routing
  input wire logic test_scan_self_i, // Test port scans manager itself
  output logic test_to_chain_o, // Test port routed to target chain
  // Outputs
  output logic [1:0] active_src_o,
  output logic [2:0] design_index_o,
  output logic card_present_o,
  output logic shift_clk_o,
  output logic busy_o,
  output logic config_progress_indicator_o,
  output logic fault_indicator_o
);
  // ==========================================================
  // State
  // ==========================================================
  cmsc_pkg::cmsc_state_e state_r; // Configuration progress
  logic fault_r; // Sticky error
  logic [1:0] src_r; // Latched source
  logic [2:0] design_r; // Latched design index
  logic card_r; // Tracked card presence
  logic [2:0] rate_r; // Latched rate selection
  logic [7:0] div_r; // Shift clock divider
  logic shift_r; // Shift clock
  logic gnt_mpu_r; // Buffer owner: processor
  logic gnt_jtag_r; // Buffer owner: chain loader
  logic blink; // Shared blink wave
  logic [2:0] design_nxt; // Selected design this cycle

  cmsc_blink #(.HALF_CYC(BLINK_HALF)) u_blink (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .blink_o(blink)
  );

  // Pick register select over pins when enabled
  assign design_nxt = mpu_design_sel_en_i ? mpu_design_sel_i
                                          : design_select_inputs_i; // R14

  // ==========================================================
  // Configuration state machine
  // ==========================================================
  // Attempt starts from idle or done, so a new start reruns loading; start is ignored while busy
  always_ff @(posedge clk_i) begin
    if (reset_i) begin // R07
      state_r <= cmsc_pkg::CMSC_ST_IDLE;
      src_r <= cmsc_pkg::CMSC_SRC_CARD;
      design_r <= '0;
    end else begin
      case (state_r)
        cmsc_pkg::CMSC_ST_BUSY: begin
          // Error aborts the attempt back to idle
          if (error_i) begin
            state_r <= cmsc_pkg::CMSC_ST_IDLE;
          end else if (done_i) begin
            state_r <= cmsc_pkg::CMSC_ST_DONE; // R01
          end
        end
        default: begin
          if (start_i) begin // R08
            state_r <= cmsc_pkg::CMSC_ST_BUSY;
            src_r <= src_sel_i;
            design_r <= design_nxt; // R14
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Card presence and fault tracking
  // ==========================================================
  // Presence sampled every cycle; inputs are synchronous
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      card_r <= 1'b0;
    end else begin
      card_r <= ~card_detect_n_i; // R12
    end
  end

  // Error set wins over clear from a new start in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fault_r <= 1'b0;
    end else if (error_i) begin
      fault_r <= 1'b1; // R04
    end else if (start_i && state_r != cmsc_pkg::CMSC_ST_BUSY) begin
      fault_r <= 1'b0; // R16
    end
  end

  // ==========================================================
  // Indicators
  // ==========================================================
  // Progress: on when done, blink while busy, off when idle
  always_comb begin
    case (state_r)
      cmsc_pkg::CMSC_ST_DONE: config_progress_indicator_o = 1'b1; // R01
      cmsc_pkg::CMSC_ST_BUSY: config_progress_indicator_o = blink; // R02
      default: config_progress_indicator_o = 1'b0; // R03
    endcase
  end

  // Fault: error steady beats missing-card blink
  always_comb begin
    if (fault_r) begin
      fault_indicator_o = 1'b1; // R16
    end else if (src_r == cmsc_pkg::CMSC_SRC_CARD && !card_r) begin
      fault_indicator_o = blink; // R05
    end else begin
      fault_indicator_o = 1'b0; // R06
    end
  end

  // ==========================================================
  // Shift clock divider
  // ==========================================================
  // Half period is 2**rate cycles; rate 0 gives clk/2, 12.5 MHz,
  // the fastest step that stays under the top rate
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rate_r <= cmsc_pkg::RATE_SEL_W_RST;
      div_r <= '0;
      shift_r <= 1'b0;
    end else begin
      rate_r <= rate_sel_i;
      if (state_r != cmsc_pkg::CMSC_ST_BUSY) begin
        div_r <= '0;
        shift_r <= 1'b0;
      end else if (div_r >= (8'h01 << rate_r) - 8'h01) begin // R11
        div_r <= '0;
        shift_r <= ~shift_r;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Card buffer arbiter
  // ==========================================================
  // Owner keeps grant until it drops request; loader has priority
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gnt_mpu_r <= 1'b0;
      gnt_jtag_r <= 1'b0;
    end else if (gnt_mpu_r) begin
      gnt_mpu_r <= mpu_buf_req_i;
    end else if (gnt_jtag_r) begin
      gnt_jtag_r <= jtag_buf_req_i;
    end else if (jtag_buf_req_i) begin
      gnt_jtag_r <= 1'b1; // R13
    end else begin
      gnt_mpu_r <= mpu_buf_req_i; // R09
    end
  end

  assign mpu_buf_gnt_o = gnt_mpu_r;
  assign jtag_buf_gnt_o = gnt_jtag_r;
  assign test_to_chain_o = ~test_scan_self_i; // R10
  assign active_src_o = src_r;
  assign design_index_o = design_r;
  assign card_present_o = card_r;
  assign shift_clk_o = shift_r;
  assign busy_o = (state_r == cmsc_pkg::CMSC_ST_BUSY);

  // ==========================================================
  // Checks
  // ==========================================================
  property p_done_on;
    @(posedge clk_i) disable iff (reset_i)
    state_r == cmsc_pkg::CMSC_ST_DONE |-> config_progress_indicator_o;
  endproperty
  a_done_on: assert property (p_done_on) // R01
    else $error("progress indicator not on when done");

  property p_busy_blink;
    @(posedge clk_i) disable iff (reset_i)
    busy_o |-> config_progress_indicator_o == blink;
  endproperty
  a_busy_blink: assert property (p_busy_blink) // R02
    else $error("progress indicator not blinking while busy");

  property p_idle_off;
    @(posedge clk_i) disable iff (reset_i)
    state_r == cmsc_pkg::CMSC_ST_IDLE |-> !config_progress_indicator_o;
  endproperty
  a_idle_off: assert property (p_idle_off) // R03
    else $error("progress indicator lit while idle");

  property p_err_on;
    @(posedge clk_i) disable iff (reset_i)
    error_i |=> fault_indicator_o [*2];
  endproperty
  a_err_on: assert property (p_err_on) // R04
    else $error("fault indicator not on after error");

  property p_nocard;
    @(posedge clk_i) disable iff (reset_i)
    !fault_r && src_r == cmsc_pkg::CMSC_SRC_CARD && !card_r
      |-> fault_indicator_o == blink;
  endproperty
  a_nocard: assert property (p_nocard) // R05
    else $error("fault indicator not blinking without card");

  property p_fault_off;
    @(posedge clk_i) disable iff (reset_i)
    !fault_r && (card_r || src_r != cmsc_pkg::CMSC_SRC_CARD)
      |-> !fault_indicator_o;
  endproperty
  a_fault_off: assert property (p_fault_off) // R06
    else $error("fault indicator lit without cause");

  property p_reset;
    @(posedge clk_i)
    reset_i |=> state_r == cmsc_pkg::CMSC_ST_IDLE && !fault_r && !busy_o;
  endproperty
  a_reset: assert property (p_reset) // R07
    else $error("reset did not clear state");

  property p_one_gnt;
    @(posedge clk_i) disable iff (reset_i)
    !(mpu_buf_gnt_o && jtag_buf_gnt_o);
  endproperty
  a_one_gnt: assert property (p_one_gnt) // R13
    else $error("buffer granted to both requesters");

  property p_design;
    @(posedge clk_i) disable iff (reset_i)
    start_i && state_r != cmsc_pkg::CMSC_ST_BUSY
      |=> design_r == $past(design_nxt);
  endproperty
  a_design: assert property (p_design) // R14
    else $error("design index not latched at start");

  property p_fault_hold;
    @(posedge clk_i) disable iff (reset_i)
    fault_r && !start_i |=> fault_r;
  endproperty
  a_fault_hold: assert property (p_fault_hold) // R16
    else $error("fault dropped without new attempt");
endmodule : cmsc_top
`default_nettype wire

// >>> shared/cmsc_pkg.sv
// Operation
// R01: Progress indicator steady on after successful configuration
// R02: Progress indicator blinks while configuration runs
// R03: Progress indicator off while logic idle
// R04: Fault indicator steady on after any error
// R05: Fault blinks when card source lacks card
// R06: Fault indicator off when no error
// R07: Reset pin returns everything to initial state
// R08: Chain configurable from card, processor or test
// R09: Processor reaches card, chain and local control
// R10: Test port scans chain or manager itself
// R11: Selectable shift rate, fastest 16.7 Mbit/s; code tops out at clk/2, 12.5 MHz
// R12: Card presence detected and tracked
// R13: Card buffer granted to one requester only
// R14: Three select bits choose one of eight designs
// R15: Blink from divider near 2 Hz, 50 percent
// R16: Fault held until reset or new attempt

package cmsc_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 25000000; // Device clock rate
  localparam int unsigned BLINK_HZ = 2; // Visible blink rate
  // Half period of blink in cycles, 50 percent duty
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned BLINK_CNT_W = 23; // Fits BLINK_HALF_CYC
  localparam int unsigned MAX_RATE_KBPS = 16700; // Fastest shift rate
  // Shift clock toggles each half period; fastest is clk/2 = 12.5 MHz,
  // the nearest step not above the top rate
  localparam logic [2:0] RATE_SEL_W_RST = 3'h0; // Fastest rate at reset
  localparam int unsigned RATE_W = 3; // Rate select width
  localparam int unsigned DESIGN_SEL_W = 3; // Design select width
  localparam int unsigned NUM_DESIGNS = 8; // Designs in collection
  localparam logic [3:0] DIV_CNT_RST = 4'h0; // Divider counter reset

  // ==========================================================
  // Configuration sources and states
  // ==========================================================
  typedef enum logic [1:0] {
    CMSC_SRC_CARD = 2'h0,
    CMSC_SRC_MPU = 2'h1,
    CMSC_SRC_TEST = 2'h2,
    CMSC_SRC_NONE = 2'h3
  } cmsc_src_e;

  typedef enum logic [1:0] {
    CMSC_ST_IDLE,
    CMSC_ST_BUSY,
    CMSC_ST_DONE
  } cmsc_state_e;
endpackage : cmsc_pkg

// >>> src/cmsc_blink.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Blink divider: square wave near 2 Hz
// ============================================================
module cmsc_blink #(
  parameter int unsigned HALF_CYC = cmsc_pkg::BLINK_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  output logic blink_o
);
  logic [cmsc_pkg::BLINK_CNT_W-1:0] cnt_r; // Half period counter
  logic blink_r; // Square wave

  // Count half periods and toggle, equal high and low time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (cnt_r == cmsc_pkg::BLINK_CNT_W'(HALF_CYC - 1)) begin // R15
      cnt_r <= '0;
      blink_r <= ~blink_r;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign blink_o = blink_r;
endmodule : cmsc_blink
`default_nettype wire

// >>> tb/cmsc_chain_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Target chain stand-in: loads after a fixed count of shift edges
module cmsc_chain_model #(
  parameter int LOAD_EDGES = 10 // Shift edges in one bitstream
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic busy_i,
  input wire logic shift_clk_i,
  input wire logic fail_i, // Bench asks for a failed load
  output logic done_o,
  output logic error_o
);
  int edges; // Rising shift edges seen in this load
  logic shift_q; // Last shift level, for edge finding
  // Count only while a load runs; a stalled shift clock never finishes
  always @(posedge clk_i) begin
    shift_q <= shift_clk_i;
    if (reset_i || !busy_i) edges <= 0;
    else if (shift_clk_i && !shift_q) edges <= edges + 1;
  end
  // Answer once the whole stream arrived, held until the load ends
  assign done_o = busy_i && (edges >= LOAD_EDGES) && !fail_i;
  assign error_o = busy_i && (edges >= LOAD_EDGES) && fail_i;
endmodule : cmsc_chain_model
`default_nettype wire

// >>> tb/test_config_manager_status_control.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// Bench for the status and control block
module test_config_manager_status_control;
  logic clk_i = 0, reset_i = 1; // Clock and reset
  logic [1:0] src = 0; // Requested source
  logic start = 0, card_n = 0, fail = 0, en = 0, mreq = 0, jreq = 0;
  logic self_scan = 0; // Test port scans manager
  logic [2:0] pins = 0, msel = 0, rate = 0;
  logic done, error, mgnt, jgnt, to_chain, card, shift, busy, prog, fault;
  logic [1:0] src_o; // Latched source
  logic [2:0] idx; // Chosen design
  int miscompares = 0, check_count = 0;
  // Short blink half period keeps the run brief
  always #20 clk_i = ~clk_i;
  cmsc_top #(.BLINK_HALF(4)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .src_sel_i(src), .start_i(start), .done_i(done), .error_i(error),
    .card_detect_n_i(card_n), .design_select_inputs_i(pins),
    .mpu_design_sel_i(msel), .mpu_design_sel_en_i(en), .rate_sel_i(rate),
    .mpu_buf_req_i(mreq), .jtag_buf_req_i(jreq), .mpu_buf_gnt_o(mgnt),
    .jtag_buf_gnt_o(jgnt), .test_scan_self_i(self_scan),
    .test_to_chain_o(to_chain), .active_src_o(src_o),
    .design_index_o(idx), .card_present_o(card), .shift_clk_o(shift),
    .busy_o(busy), .config_progress_indicator_o(prog),
    .fault_indicator_o(fault));
  cmsc_chain_model #(.LOAD_EDGES(10)) chain (.clk_i(clk_i),
    .reset_i(reset_i), .busy_i(busy), .shift_clk_i(shift), .fail_i(fail),
    .done_o(done), .error_o(error));
  // ==========
  // Helpers
  task automatic summarize();
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [2:0] exp,
                     input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  // Pattern over 12 cycles: 1 off, 2 steady on, 3 blinking
  task automatic look(input string what, input bit sel, input logic [1:0] e);
    logic s0, s1, v;
    s0 = 0;
    s1 = 0;
    repeat (12) begin
      @(negedge clk_i);
      v = sel ? fault : prog;
      if (v === 1'b0) s0 = 1;
      else if (v === 1'b1) s1 = 1;
    end
    chk(what, {1'b0, e}, {1'b0, s1, s0});
  endtask : look
  // Inputs change on the falling edge only
  task automatic go(input logic [1:0] s, input logic [2:0] r, input bit f);
    src = s;
    rate = r;
    fail = f;
    start = 1;
    wt(1);
    start = 0;
    chk("busy", 3'h1, {2'b0, busy});
    chk("source", {1'b0, s}, {1'b0, src_o});
  endtask : go
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      wt(1);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      $display("wrong value busy exp 0 got %b", busy);
      summarize();
    end
  endtask : wait_idle
  // Wait for the next shift clock change, bounded; n counts the cycles
  task automatic edge_wait(output int n);
    logic v;
    v = shift;
    n = 0;
    while (shift === v && n < 20) begin
      wt(1);
      n++;
    end
    if (n >= 20) begin
      miscompares++;
      $display("wrong value shift edge exp toggle got stuck");
      summarize();
    end
  endtask : edge_wait
  // ==========
  // Scenarios
  task automatic t_reset();
    chk("busy", 3'h0, {2'b0, busy});
    chk("grants", 3'h0, {1'b0, mgnt, jgnt});
    look("progress", 0, 2'h1);
    look("fault", 1, 2'h1);
  endtask : t_reset
  task automatic t_load();
    for (int s = 0; s < 4; s++) begin
      go(s[1:0], 3'h0, 0);
      look("progress", 0, 2'h3);
      wait_idle();
      look("progress", 0, 2'h2);
      look("fault", 1, 2'h1);
    end
  endtask : t_load
  task automatic t_rate();
    int n;
    for (int r = 0; r < 3; r++) begin
      go(2'h0, r[2:0], 0);
      // First change lines up with the divider, second measures it
      edge_wait(n);
      edge_wait(n);
      chk("half period", 3'(1 << r), n[2:0]);
      wait_idle();
    end
  endtask : t_rate
  task automatic t_error();
    go(2'h1, 3'h0, 1);
    wait_idle();
    look("fault", 1, 2'h2);
    look("progress", 0, 2'h1);
    go(2'h1, 3'h0, 0);
    chk("fault", 3'h0, {2'b0, fault});
    wait_idle();
  endtask : t_error
  task automatic t_card();
    go(2'h0, 3'h0, 0);
    wait_idle();
    card_n = 1;
    wt(2);
    chk("card", 3'h0, {2'b0, card});
    look("fault", 1, 2'h3);
    go(2'h0, 3'h0, 1);
    wait_idle();
    look("fault", 1, 2'h2);
    card_n = 0;
  endtask : t_card
  task automatic t_reset_mid();
    go(2'h2, 3'h2, 0);
    wt(5);
    reset_i = 1;
    wt(1);
    reset_i = 0;
    chk("busy", 3'h0, {2'b0, busy});
    chk("shift", 3'h0, {2'b0, shift});
    look("progress", 0, 2'h1);
    look("fault", 1, 2'h1);
  endtask : t_reset_mid
  task automatic t_arb();
    mreq = 1;
    jreq = 1;
    wt(2);
    chk("grants", 3'h1, {1'b0, mgnt, jgnt});
    jreq = 0;
    wt(2);
    chk("grants", 3'h2, {1'b0, mgnt, jgnt});
    mreq = 0;
    wt(2);
    chk("grants", 3'h0, {1'b0, mgnt, jgnt});
  endtask : t_arb
  task automatic t_design();
    // Design index is only latched when an attempt starts
    for (int i = 0; i < 8; i++) begin
      pins = i[2:0];
      msel = ~i[2:0];
      en = 0;
      go(2'h1, 3'h0, 0);
      chk("design pins", i[2:0], idx);
      wait_idle();
      en = 1;
      go(2'h1, 3'h0, 0);
      chk("design reg", ~i[2:0], idx);
      wait_idle();
    end
    en = 0;
  endtask : t_design
  task automatic t_test();
    self_scan = 1;
    wt(1);
    chk("to chain", 3'h0, {2'b0, to_chain});
    self_scan = 0;
    wt(1);
    chk("to chain", 3'h1, {2'b0, to_chain});
  endtask : t_test
  // Main sequence: reset held for three cycles
  initial begin
    wt(3);
    reset_i = 0;
    wt(1);
    t_reset();
    t_load();
    t_rate();
    t_error();
    t_card();
    t_reset_mid();
    t_arb();
    t_design();
    t_test();
    summarize();
  end
endmodule : test_config_manager_status_control
`default_nettype wire
